// ### rtl/pic_board_end.sv
`timescale 1ns/1ps
module pic_board_end #(
  parameter int unsigned LEAD_CYC = pic_pkg::PD_LEAD_CYC,
  parameter int unsigned MDC_HALF = pic_pkg::MDC_HALF_CYC
) (
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  pic_if.board_mp          lnk
);
  import pic_pkg::*;

  typedef enum logic [1:0] {H_OFF, H_LEAD, H_ON} pic_pwr_type;
  typedef enum logic [1:0] {S_IDLE, S_ARM, S_HOLD, S_WAIT} pic_smi_type;

  // Whole module state
  typedef struct packed {
    pic_pins_type pins;
    pic_pwr_type  pwr;
    logic [21:0]  lead;
    logic [7:0]   div;
    pic_smi_type  smi;
    logic         smi_rd;
    logic [4:0]   smi_addr;
    logic [15:0]  smi_wdata;
    logic [15:0]  rs1;
    logic [15:0]  rs2;
    logic [15:0]  smi_rdata;
    logic [31:0]  rdata;
  } pic_board_state_type;

  pic_board_state_type r_ff;     // Registered state
  pic_board_state_type nxt_r;    // Next state
  logic                mdc_tick; // Half period of MDC done
  logic                mdc_fall; // MDC about to fall

  assign lnk.pins  = r_ff.pins;
  assign rdata_out = r_ff.rdata;

  // Sequencing, MDC divider, management and command port
  always_comb begin
    nxt_r     = r_ff;
    mdc_tick  = (r_ff.div == 8'(MDC_HALF - 1));
    mdc_fall  = mdc_tick & r_ff.pins.mdc;
    nxt_r.rs1 = lnk.mgmt_rdata;
    nxt_r.rs2 = r_ff.rs1;
    // Free-running MDC from the core clock
    nxt_r.div = r_ff.div + 8'h01;
    if (mdc_tick) begin
      nxt_r.div      = 8'h00;
      nxt_r.pins.mdc = ~r_ff.pins.mdc;
    end
    // Reset held low until the power-down lead time runs out
    case (r_ff.pwr)
      H_LEAD: begin
        nxt_r.lead = r_ff.lead + 22'h1;
        if (r_ff.lead == 22'(LEAD_CYC - 1)) begin
          nxt_r.pins.reset_n_pin = 1'b1;
          nxt_r.pwr              = H_ON;
        end
      end
      H_OFF:   nxt_r.pwr = H_OFF;
      H_ON:    nxt_r.pwr = H_ON;
      default: nxt_r.pwr = H_OFF;
    endcase
    // Strobes change on MDC fall so they are steady at the rise
    case (r_ff.smi)
      S_ARM: begin
        if (mdc_fall) begin
          nxt_r.pins.mgmt_wr    = ~r_ff.smi_rd;
          nxt_r.pins.mgmt_rd    = r_ff.smi_rd;
          nxt_r.pins.mgmt_addr  = r_ff.smi_addr;
          nxt_r.pins.mgmt_wdata = r_ff.smi_wdata;
          nxt_r.smi             = S_HOLD;
        end
      end
      S_HOLD: begin
        if (mdc_fall) begin
          nxt_r.pins.mgmt_wr = 1'b0;
          nxt_r.pins.mgmt_rd = 1'b0;
          nxt_r.smi          = r_ff.smi_rd ? S_WAIT : S_IDLE;
        end
      end
      S_WAIT: begin
        // One MDC period gives the PHY answer ample settling time
        if (mdc_fall) begin
          nxt_r.smi_rdata = r_ff.rs2;
          nxt_r.smi       = S_IDLE;
        end
      end
      S_IDLE:  nxt_r.smi = S_IDLE;
      default: nxt_r.smi = S_IDLE;
    endcase
    // Command port writes
    if (wr_in) begin
      case (addr_in)
        H_STRAP: begin
          nxt_r.pins.speed_force_pins    = wdata_in[2:0];
          nxt_r.pins.duplex_force_pin    = wdata_in[3];
          nxt_r.pins.autoneg_disable_pin = wdata_in[4];
        end
        H_POWER: begin
          if (wdata_in[0]) begin
            nxt_r.pins.power_down_n_pin = 1'b1;
            nxt_r.pins.reset_n_pin      = 1'b0;
            nxt_r.lead                  = 22'h0;
            nxt_r.pwr                   = H_LEAD;
          end else if (wdata_in[1]) begin
            nxt_r.pins.power_down_n_pin = 1'b0;
            nxt_r.pins.reset_n_pin      = 1'b0;
            nxt_r.pwr                   = H_OFF;
          end
        end
        H_SMI: begin
          // Ignored while a transfer is in flight
          if (r_ff.smi == S_IDLE) begin
            nxt_r.smi_addr  = wdata_in[4:0];
            nxt_r.smi_rd    = wdata_in[SMI_RD_BIT];
            nxt_r.smi_wdata = wdata_in[SMI_DATA_LSB +: 16];
            nxt_r.smi       = S_ARM;
          end
        end
        default: nxt_r.smi = nxt_r.smi;
      endcase
    end
    // Command port reads, data one cycle later
    nxt_r.rdata = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        H_STRAP:    nxt_r.rdata = {27'h0, r_ff.pins.autoneg_disable_pin,
                                   r_ff.pins.duplex_force_pin, r_ff.pins.speed_force_pins};
        H_POWER:    nxt_r.rdata = {29'h0, r_ff.pwr == H_LEAD,
                                   r_ff.pins.reset_n_pin, r_ff.pins.power_down_n_pin};
        H_SMI:      nxt_r.rdata = {31'h0, r_ff.smi != S_IDLE};
        H_SMI_DATA: nxt_r.rdata = {16'h0, r_ff.smi_rdata};
        default:    nxt_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Single state register, PHY held in power-down and reset
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      r_ff <= '{pwr: H_OFF, smi: S_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end
endmodule

// ### rtl/pic_if.sv
`timescale 1ns/1ps
interface pic_if;
  pic_pkg::pic_pins_type pins;       // Board straps, reset, management
  logic [15:0]           mgmt_rdata; // PHY read data, held until next read

  modport phy_mp   (input pins, output mgmt_rdata);
  modport board_mp (output pins, input mgmt_rdata);
endinterface

// ### rtl/pic_phy_end.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Power-down released 10 ms before reset release
// - Analog bias settles within 10 ms
// - 50 us PLL lock, everything held default
// - Autoneg plus parallel detect, then link up
// - Force pins shape advertisement only when disabled-pin high
// - Strap pins watched live; change restarts negotiation
// - Board drives straps during reset, disable high; board end holds all straps low, disable included, until an H_STRAP write
// - Strapped values used; result shown in 28.5:3
// - Pins override management speed and duplex bits in manual mode (0.12 clear) when disable-pin high
// - Negotiates alone right after reset
// - Restart on resets, 0.9, 0.11 clear, link fail
// - Partner capable: best common; else parallel detect
// - Gigabit resolves master/slave and carries next pages
// - TBI modes send MAC default clause-37 word
// - Code 111 in 24.9:7 stops that word
// - Resets give 3.3V GMII; only reg 23 changes
// - 23.15:12 mode, 23.11:9 I/O, 23.8 compensation
// - GMII falls back to MII below gigabit
// - RGMII: MAC drives TXC, PHY drives RXC
// - Software keeps interface mode fixed in operation
// - Reset pin low resets without MDC
// - Software reset on MDC, clocks keep running
module pic_phy_end #(
  parameter int unsigned LEAD_CYC = pic_pkg::PD_LEAD_CYC,
  parameter int unsigned BIAS_CYC = pic_pkg::BIAS_CYC,
  parameter int unsigned PLL_CYC  = pic_pkg::PLL_LOCK_CYC,
  parameter int unsigned AN_CYC   = pic_pkg::AN_WAIT_CYC,
  parameter logic [9:0]  SEED     = 10'h2A5 // Arbitrary role seed
) (
  input  wire logic               core_clk_in,
  input  wire logic               nrst_in,
  pic_if.phy_mp                   lnk,
  input  wire logic               partner_an_in,
  input  wire logic [2:0]         partner_abil_in,
  input  wire logic               partner_full_in,
  input  wire logic [9:0]         partner_seed_in,
  input  wire logic [15:0]        partner_np_in,
  input  wire logic               link_ok_in,
  output logic      [3:0]         mac_mode_out,
  output logic      [2:0]         io_level_out,
  output logic                    rgmii_comp_out,
  output logic                    mii_fallback_out,
  output pic_pkg::pic_spd_type    speed_out,
  output logic                    full_duplex_out,
  output logic                    master_out,
  output logic                    link_up_out,
  output logic                    mac_clk_run_out,
  output logic                    tbi_cfg_send_out,
  output logic      [15:0]        tbi_cfg_word_out,
  output logic      [15:0]        np_tx_out
);
  import pic_pkg::*;

  typedef enum logic [2:0] {
    ST_HWRST, ST_STALL, ST_PLL, ST_PDOWN, ST_AN, ST_LINK_WAIT, ST_UP, ST_FAIL
  } pic_phy_st_type;

  // Whole module state
  typedef struct packed {
    pic_pins_type   s1;         // First sync stage, read only by s2
    pic_pins_type   s2;         // Second sync stage
    logic           mdc_prev;
    logic [4:0]     strap_prev;
    pic_phy_st_type st;
    logic [21:0]    cnt;
    logic [21:0]    lead_cnt;
    logic [21:0]    bias_cnt;
    logic [15:0]    ctl;
    logic [15:0]    np_tx;
    logic [15:0]    np_rx;
    logic [15:0]    ext1;
    logic [15:0]    fifo;
    logic [15:0]    rdata;
    pic_spd_type    spd;
    logic           full;
    logic           master;
    logic           link;
    logic           fallback;
    logic           tbi_send;
    logic           clk_run;
  } pic_phy_state_type;

  pic_phy_state_type r_ff;      // Registered state
  pic_phy_state_type nxt_r;     // Next state
  pic_pins_type      p;         // Synchronised pins
  logic [4:0]        strap;     // Live strap levels
  logic              mdc_rise;  // Management sample point
  logic              restart;   // Negotiation (re)start request
  logic              running;   // Past lock, power-down included
  logic [2:0]        adv_abil;  // Advertised speeds
  logic              adv_full;  // Advertised full duplex
  logic [2:0]        common;    // Speeds both sides share

  // Management-visible registers back to defaults
  function automatic pic_phy_state_type reg_dflt(input pic_phy_state_type s);
    s.ctl   = CTRL_RST_VAL;
    s.np_tx = 16'h0000;
    s.np_rx = 16'h0000;
    s.ext1  = EXT1_RST_VAL;
    s.fifo  = FIFO_RST_VAL;
    return s;
  endfunction

  // All outputs straight from state flops
  assign mac_mode_out     = r_ff.ext1[EXT_MODE_MSB:EXT_MODE_LSB];
  assign io_level_out     = r_ff.ext1[EXT_IO_MSB:EXT_IO_LSB];
  assign rgmii_comp_out   = r_ff.ext1[EXT_COMP];
  assign mii_fallback_out = r_ff.fallback;
  assign speed_out        = r_ff.spd;
  assign full_duplex_out  = r_ff.full;
  assign master_out       = r_ff.master;
  assign link_up_out      = r_ff.link;
  assign mac_clk_run_out  = r_ff.clk_run;
  assign tbi_cfg_send_out = r_ff.tbi_send;
  assign tbi_cfg_word_out = r_ff.tbi_send ? TBI_CFG_WORD : 16'h0000;
  assign np_tx_out        = r_ff.np_tx;
  assign lnk.mgmt_rdata   = r_ff.rdata;

  // Start-up sequence, negotiation and management
  always_comb begin
    nxt_r    = r_ff;
    p        = r_ff.s2;
    strap    = {p.speed_force_pins, p.duplex_force_pin, p.autoneg_disable_pin};
    mdc_rise = p.mdc & ~r_ff.mdc_prev;
    restart  = 1'b0;
    running  = 1'b0;
    // Pins shape advertisement only with the disable pin high
    adv_abil = p.autoneg_disable_pin ? p.speed_force_pins : 3'h7;
    adv_full = p.autoneg_disable_pin ? p.duplex_force_pin : 1'b1;
    common   = adv_abil & partner_abil_in;
    nxt_r.s1         = lnk.pins;
    nxt_r.s2         = r_ff.s1;
    nxt_r.mdc_prev   = p.mdc;
    nxt_r.strap_prev = strap;
    // Bias settles a fixed time after supplies come up
    if (r_ff.bias_cnt != 22'(BIAS_CYC - 1)) begin
      nxt_r.bias_cnt = r_ff.bias_cnt + 22'h1;
    end
    // Measure how long power-down has been released
    if (!p.power_down_n_pin) begin
      nxt_r.lead_cnt = 22'h0;
    end else if (r_ff.lead_cnt != 22'(LEAD_CYC - 1)) begin
      nxt_r.lead_cnt = r_ff.lead_cnt + 22'h1;
    end
    if (!p.reset_n_pin) begin
      // Level-driven, needs no MDC edge
      nxt_r         = reg_dflt(nxt_r);
      nxt_r.st      = ST_HWRST;
      nxt_r.cnt     = 22'h0;
      nxt_r.link    = 1'b0;
      nxt_r.spd     = SPD_1000;
      nxt_r.full    = 1'b1;
      nxt_r.master  = 1'b0;
      nxt_r.rdata   = 16'h0000;
    end else begin
      case (r_ff.st)
        ST_HWRST: begin
          // Reset released too early: power-up never completes
          if (r_ff.lead_cnt == 22'(LEAD_CYC - 1) &&
              r_ff.bias_cnt == 22'(BIAS_CYC - 1)) begin
            nxt_r.st  = ST_PLL;
            nxt_r.cnt = 22'h0;
          end else begin
            nxt_r.st = ST_STALL;
          end
        end
        ST_STALL: nxt_r.st = ST_STALL; // Left only by reset pin
        ST_PLL: begin
          // Registers stay default, management ignored
          nxt_r.cnt = r_ff.cnt + 22'h1;
          if (r_ff.cnt == 22'(PLL_CYC - 1)) begin
            restart = 1'b1;
          end
        end
        ST_PDOWN: begin
          if (p.power_down_n_pin && !r_ff.ctl[CTL_PDOWN]) begin
            restart = 1'b1;
          end
        end
        ST_AN: begin
          nxt_r.cnt = r_ff.cnt + 22'h1;
          if (r_ff.cnt == 22'(AN_CYC - 1)) begin
            if (partner_an_in) begin
              // Best common mode, role and next page
              nxt_r.spd    = pic_best_speed(common);
              nxt_r.full   = adv_full & partner_full_in;
              nxt_r.master = (SEED > partner_seed_in);
              nxt_r.np_rx  = partner_np_in;
              nxt_r.st     = (common == 3'h0) ? ST_FAIL : ST_LINK_WAIT;
            end else begin
              // Parallel detect cannot learn duplex: half
              nxt_r.spd  = pic_best_speed(partner_abil_in);
              nxt_r.full = 1'b0;
              nxt_r.st   = ST_LINK_WAIT;
            end
          end
        end
        ST_LINK_WAIT: begin
          if (link_ok_in) begin
            nxt_r.st   = ST_UP;
            nxt_r.link = 1'b1;
          end
        end
        ST_UP: begin
          if (!link_ok_in) begin
            nxt_r.st   = ST_FAIL;
            nxt_r.link = 1'b0;
          end
        end
        ST_FAIL:  restart = 1'b1;
        default:  nxt_r.st = ST_HWRST;
      endcase
      running = (r_ff.st != ST_HWRST) && (r_ff.st != ST_STALL) && (r_ff.st != ST_PLL);
      // Straps are never latched
      if (running && strap != r_ff.strap_prev) begin
        restart = 1'b1;
      end
      // Management access at each MDC rise once locked
      if (running && mdc_rise && p.mgmt_wr) begin
        case (p.mgmt_addr)
          REG_CTRL: begin
            if (p.mgmt_wdata[CTL_SW_RST]) begin
              nxt_r   = reg_dflt(nxt_r);
              restart = 1'b1;
            end else begin
              nxt_r.ctl             = p.mgmt_wdata;
              nxt_r.ctl[CTL_AN_RST] = 1'b0; // Self-clearing
              if (p.mgmt_wdata[CTL_AN_RST] ||
                  (r_ff.ctl[CTL_PDOWN] && !p.mgmt_wdata[CTL_PDOWN])) begin
                restart = 1'b1;
              end
            end
          end
          REG_NP_TX: nxt_r.np_tx = p.mgmt_wdata;
          REG_EXT1:  nxt_r.ext1  = p.mgmt_wdata;
          REG_FIFO:  nxt_r.fifo  = p.mgmt_wdata;
          default:   nxt_r.rdata = r_ff.rdata; // Unmapped writes dropped
        endcase
      end
      if (running && mdc_rise && p.mgmt_rd) begin
        case (p.mgmt_addr)
          REG_CTRL:  nxt_r.rdata = r_ff.ctl;
          REG_NP_TX: nxt_r.rdata = r_ff.np_tx;
          REG_NP_RX: nxt_r.rdata = r_ff.np_rx;
          REG_EXT1:  nxt_r.rdata = r_ff.ext1;
          REG_FIFO:  nxt_r.rdata = r_ff.fifo;
          REG_AUX:   nxt_r.rdata = {10'h0, r_ff.spd, r_ff.full, 3'h0};
          default:   nxt_r.rdata = 16'h0000;
        endcase
      end
      if (restart) begin
        nxt_r.cnt  = 22'h0;
        nxt_r.link = 1'b0;
        if (nxt_r.ctl[CTL_AN_EN]) begin
          nxt_r.st = ST_AN;
        end else begin
          // Manual mode: pins win when the disable pin is high
          nxt_r.st = ST_LINK_WAIT;
          if (p.autoneg_disable_pin) begin
            nxt_r.spd  = pic_best_speed(p.speed_force_pins);
            nxt_r.full = p.duplex_force_pin;
          end else begin
            nxt_r.spd  = {nxt_r.ctl[CTL_SPD_MSB], nxt_r.ctl[CTL_SPD_LSB]};
            nxt_r.full = nxt_r.ctl[CTL_DUPLEX];
          end
        end
      end
      // Power-down (pin or bit) outranks all but the reset pin; values kept
      if (running && (!p.power_down_n_pin || nxt_r.ctl[CTL_PDOWN])) begin
        nxt_r.st   = ST_PDOWN;
        nxt_r.link = 1'b0;
      end
    end
    // MII fallback below gigabit in GMII mode
    nxt_r.fallback = (nxt_r.ext1[EXT_MODE_MSB:EXT_MODE_LSB] == MODE_GMII) &&
                     (nxt_r.spd != SPD_1000);
    // Clause-37 word toward a TBI MAC unless turned off
    nxt_r.tbi_send = ((nxt_r.ext1[EXT_MODE_MSB:EXT_MODE_LSB] == MODE_TBI) ||
                      (nxt_r.ext1[EXT_MODE_MSB:EXT_MODE_LSB] == MODE_REDUCED_TBI)) &&
                     (nxt_r.fifo[FIFO_LAT_MSB:FIFO_LAT_LSB] != TBI_AN_OFF);
    // PHY sources the receive clock; a software reset keeps it going
    nxt_r.clk_run = (nxt_r.st != ST_HWRST) && (nxt_r.st != ST_STALL) &&
                    (nxt_r.st != ST_PLL) && (nxt_r.st != ST_PDOWN);
  end

  // Single state register
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      r_ff <= '{st: ST_HWRST, ctl: CTRL_RST_VAL, ext1: EXT1_RST_VAL, fifo: FIFO_RST_VAL,
                spd: SPD_1000, full: 1'b1, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end
endmodule

// ### rtl/pic_pkg.sv
package pic_pkg;
  // Core clock and printed times
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned PD_LEAD_MS   = 10;
  localparam int unsigned BIAS_MS      = 10;
  localparam int unsigned PLL_LOCK_US  = 50;
  // Cycle counts, the first three derived from the times
  localparam int unsigned PD_LEAD_CYC  = PD_LEAD_MS * 1000 * CLK_MHZ;
  localparam int unsigned BIAS_CYC     = BIAS_MS * 1000 * CLK_MHZ;
  localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned AN_WAIT_CYC  = 64;
  localparam int unsigned MDC_HALF_CYC = 10;
  // Management register addresses
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_NP_TX = 5'h07;
  localparam logic [4:0] REG_NP_RX = 5'h08;
  localparam logic [4:0] REG_EXT1  = 5'h17;
  localparam logic [4:0] REG_FIFO  = 5'h18;
  localparam logic [4:0] REG_AUX   = 5'h1C;
  // Control register bits
  localparam int CTL_SW_RST  = 15;
  localparam int CTL_SPD_LSB = 13;
  localparam int CTL_AN_EN   = 12;
  localparam int CTL_PDOWN   = 11;
  localparam int CTL_AN_RST  = 9;
  localparam int CTL_DUPLEX  = 8;
  localparam int CTL_SPD_MSB = 6;
  localparam logic [15:0] CTRL_RST_VAL = 16'h1140;
  // Extended control fields
  localparam int EXT_MODE_MSB = 15;
  localparam int EXT_MODE_LSB = 12;
  localparam int EXT_IO_MSB   = 11;
  localparam int EXT_IO_LSB   = 9;
  localparam int EXT_COMP     = 8;
  localparam logic [15:0] EXT1_RST_VAL = 16'h0000;
  localparam logic [3:0] MODE_GMII        = 4'h0;
  localparam logic [3:0] MODE_RGMII       = 4'h1;
  localparam logic [3:0] MODE_TBI         = 4'h2;
  localparam logic [3:0] MODE_REDUCED_TBI = 4'h3;
  // TX FIFO latency field and its handshake-off code
  localparam int FIFO_LAT_MSB = 9;
  localparam int FIFO_LAT_LSB = 7;
  localparam logic [2:0]  TBI_AN_OFF   = 3'h7;
  localparam logic [15:0] FIFO_RST_VAL = 16'h0000;
  // Clause-37 word: full duplex, no pause, no remote fault
  localparam logic [15:0] TBI_CFG_WORD = 16'h0020;
  // Auxiliary status field
  localparam int AUX_RES_MSB = 5;
  localparam int AUX_RES_LSB = 3;
  // Resolved speed codes
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // Board-side command port map
  localparam logic [3:0] H_STRAP    = 4'h0;
  localparam logic [3:0] H_POWER    = 4'h4;
  localparam logic [3:0] H_SMI      = 4'h8;
  localparam logic [3:0] H_SMI_DATA = 4'hC;
  localparam int SMI_RD_BIT   = 5;
  localparam int SMI_DATA_LSB = 16;

  typedef logic [1:0] pic_spd_type;

  // Board-to-PHY pins, one bundle
  typedef struct packed {
    logic        power_down_n_pin;
    logic        reset_n_pin;
    logic [2:0]  speed_force_pins;
    logic        duplex_force_pin;
    logic        autoneg_disable_pin;
    logic        mdc;
    logic        mgmt_wr;
    logic        mgmt_rd;
    logic [4:0]  mgmt_addr;
    logic [15:0] mgmt_wdata;
  } pic_pins_type;

  // Highest speed in a 10/100/1000 ability set
  function automatic pic_spd_type pic_best_speed(input logic [2:0] abil);
    if (abil[2]) begin
      return SPD_1000;
    end else if (abil[1]) begin
      return SPD_100;
    end
    return SPD_10;
  endfunction
endpackage

// ### tb/phy_init_config_control_test.sv
`timescale 1ns/1ps
module phy_init_config_control_test;
  import pic_pkg::*;
  logic        core_clk;
  logic        nrst       = 1'b0;
  logic [3:0]  addr       = 4'h0;
  logic [31:0] wdata      = 32'h0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rdv;
  logic        partner_an = 1'b1; // Partner starts able to negotiate
  logic [2:0]  abil       = 3'h7;
  logic        pfull      = 1'b1;
  logic [9:0]  pseed      = 10'h100; // Below local seed, so local is master
  logic [15:0] pnp        = 16'h0ABC;
  logic        link_ok    = 1'b1;
  logic [3:0]  mode;
  logic [2:0]  io;
  logic        comp, fallback, full, master, link_up, clk_run, tsend;
  logic [15:0] tword, np_tx;
  pic_spd_type spd;
  int          n_mismatch = 0;
  int          n_tests    = 0;

  pic_if lnk_if ();
  pic_board_end #(.LEAD_CYC(200), .MDC_HALF(10)) pic_board_end_inst (.core_clk_in(core_clk),
    .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .lnk(lnk_if));
  pic_phy_end #(.LEAD_CYC(200), .BIAS_CYC(100), .PLL_CYC(50), .AN_CYC(8)) pic_phy_end_inst (
    .core_clk_in(core_clk), .nrst_in(nrst), .lnk(lnk_if), .partner_an_in(partner_an),
    .partner_abil_in(abil), .partner_full_in(pfull), .partner_seed_in(pseed),
    .partner_np_in(pnp), .link_ok_in(link_ok), .mac_mode_out(mode), .io_level_out(io),
    .rgmii_comp_out(comp), .mii_fallback_out(fallback), .speed_out(spd),
    .full_duplex_out(full), .master_out(master), .link_up_out(link_up),
    .mac_clk_run_out(clk_run), .tbi_cfg_send_out(tsend), .tbi_cfg_word_out(tword),
    .np_tx_out(np_tx));
  pic_properties #(.LEAD_CYC(200)) pic_properties_inst (.core_clk_in(core_clk),
    .nrst_in(nrst), .pins(lnk_if.pins), .mgmt_rdata(lnk_if.mgmt_rdata));

  // Free-running core clock, 4 ns
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command-port cycle; read data is taken in the cycle after the strobe
  task automatic cmd(input logic [3:0] a, input logic [31:0] d, input logic r);
    addr <= a;
    wdata <= d;
    wr <= !r;
    rd <= r;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    rdv = rdata;
    @(posedge core_clk);
  endtask

  // Management access, then poll busy (bounded) and fetch the last read word
  task automatic smi(input logic [4:0] r, input logic [15:0] d, input logic rdb);
    int i;
    cmd(H_SMI, {d, 10'h000, rdb, r}, 1'b0);
    i = 0;
    do begin
      cmd(H_SMI, 32'h0, 1'b1);
      i++;
    end while (rdv[0] !== 1'b0 && i < 300);
    if (rdv[0] !== 1'b0) n_mismatch++;
    cmd(H_SMI_DATA, 32'h0, 1'b1);
  endtask

  // Strap sync takes a few cycles, then bounded wait for link
  task automatic wait_link();
    int i;
    repeat (4) @(posedge core_clk);
    i = 0;
    while (link_up !== 1'b1 && i < 2000) begin
      @(posedge core_clk);
      i++;
    end
    if (link_up !== 1'b1) n_mismatch++;
  endtask

  task automatic s_power_up();
    cmd(H_POWER, 32'h1, 1'b0);
    wait_link();
    chk({spd, full, master}, {SPD_1000, 2'b11});
    chk({mode, io, fallback}, 8'h00);
    smi(REG_NP_RX, 16'h0, 1'b1);
    chk(rdv[15:0], 16'h0ABC);
  endtask

  task automatic s_modes();
    // Mode changes only while powered down, never in normal operation
    smi(REG_CTRL, 16'h1940, 1'b0);
    chk({link_up, clk_run}, 2'b00);
    for (int m = 0; m < 4; m++) begin
      smi(REG_EXT1, {4'(m), 3'(m % 2), 1'b1, 8'h00}, 1'b0);
      chk({mode, io, comp}, {4'(m), 3'(m % 2), 1'b1});
      chk({tsend, tword}, (m >= 2) ? {1'b1, TBI_CFG_WORD} : 17'h0);
    end
    smi(REG_FIFO, {6'h00, TBI_AN_OFF, 7'h00}, 1'b0);
    chk({tsend, tword}, 17'h0);
    smi(REG_EXT1, 16'h0300, 1'b0);
    chk({mode, io, comp}, 8'h03);
    smi(REG_CTRL, 16'h1140, 1'b0);
    wait_link();
    chk({link_up, fallback}, 2'b10);
  endtask

  // Line drop forces link_fail and a fresh negotiation with new partner data
  task automatic s_link_fail();
    pfull <= 1'b0;
    pseed <= 10'h3FF;
    pnp <= 16'h5A5A;
    smi(REG_NP_TX, 16'h0C3C, 1'b0);
    chk(np_tx, 16'h0C3C);
    link_ok <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(link_up, 1'b0);
    link_ok <= 1'b1;
    wait_link();
    chk({master, full}, 2'b00);
    smi(REG_NP_RX, 16'h0, 1'b1);
    chk(rdv[15:0], 16'h5A5A);
    pfull <= 1'b1;
  endtask

  task automatic s_straps();
    cmd(H_STRAP, 32'h0000001A, 1'b0);
    wait_link();
    chk({spd, full, fallback}, {SPD_100, 2'b11});
    smi(REG_AUX, 16'h0, 1'b1);
    chk(rdv[5:3], {SPD_100, 1'b1});
    cmd(H_STRAP, 32'h00000009, 1'b0);
    wait_link();
    chk({spd, full}, {SPD_1000, 1'b1});
  endtask

  task automatic s_resets();
    partner_an <= 1'b0;
    abil <= 3'h2;
    smi(REG_CTRL, 16'h1340, 1'b0);
    wait_link();
    chk({spd, full}, {SPD_100, 1'b0});
    smi(REG_CTRL, 16'h9140, 1'b0);
    chk({clk_run, mode, io, comp}, 9'h100);
    cmd(H_POWER, 32'h1, 1'b0);
    repeat (8) @(posedge core_clk);
    chk(link_up, 1'b0);
    wait_link();
    chk({link_up, spd}, {1'b1, SPD_100});
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    s_power_up();
    s_link_fail();
    s_modes();
    s_straps();
    s_resets();
    complete_run();
  end

  // Watchdog, far beyond the fewer than two thousand cycles the run needs
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
endmodule

// ### tb/pic_properties.sv
`timescale 1ns/1ps
module pic_properties import pic_pkg::*; #(
  parameter int unsigned LEAD_CYC = 200
) (
  input wire logic                  core_clk_in,
  input wire logic                  nrst_in,
  input wire pic_pkg::pic_pins_type pins,
  input wire logic [15:0]           mgmt_rdata
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [31:0] lead_ff; // Cycles with power up and reset pin still low

  // Lead counter, cleared whenever the sequence is not in its lead phase
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || !pins.power_down_n_pin || pins.reset_n_pin) begin
      lead_ff <= 32'h0;
    end else begin
      lead_ff <= lead_ff + 32'h1;
    end
  end

  chk_lead_time: assert property ($rose(pins.reset_n_pin) |-> lead_ff + 32'h1 >= LEAD_CYC)
    else $error("reset pin released before lead time");
  chk_board_idle: assert property (disable iff (1'b0) !nrst_in |=> !pins.reset_n_pin &&
    !pins.power_down_n_pin && !pins.mgmt_wr && !pins.mgmt_rd)
    else $error("board pins active in reset");
  chk_rdata_reset: assert property (disable iff (1'b0) !nrst_in |=> mgmt_rdata == 16'h0000)
    else $error("read data not cleared by reset");
  chk_mdc_high: assert property ($rose(pins.mdc) |-> pins.mdc [*8])
    else $error("management clock high phase too short");
  chk_mdc_low: assert property ($fell(pins.mdc) |-> !pins.mdc [*8])
    else $error("management clock low phase too short");
  chk_strobe_excl: assert property (!(pins.mgmt_wr && pins.mgmt_rd))
    else $error("read and write strobes together");
  chk_wr_hold: assert property ($rose(pins.mgmt_wr) |=>
    (pins.mgmt_wr && $stable(pins.mgmt_addr) && $stable(pins.mgmt_wdata)) [*8])
    else $error("write strobe or data not held");
  chk_strobe_phase: assert property ($rose(pins.mgmt_wr || pins.mgmt_rd) |-> !pins.mdc)
    else $error("strobe not raised in clock low phase");
endmodule
